/* rtl/irq_defines.svh */
// Register offsets, field positions, vectors and reset values of the
// interrupt controller. Assumes 8-bit register data in the low byte lane.
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// Byte offsets on the register bus
`define OFF_CTRL0 8'h00
`define OFF_CTRL1 8'h04
`define OFF_MCTRL 8'h08
`define OFF_STAT 8'h0C
`define OFF_MASK 8'h10
`define OFF_SVC 8'h14

// irq_ctrl_reg0 fields
`define B0_GIE 0
`define B0_CMP_EN 1
`define B0_MULTI_EN 2
`define B0_CMP_FLAG 4
// irq_ctrl_reg1 fields
`define B1_PWM_EN 0
`define B1_PWM_FLAG 4
`define B1_MULTI_FLAG 5
// multi_irq_ctrl_reg fields
`define BM_ADC_EN 0
`define BM_EXT1_EN 1
`define BM_EXT1_FLAG 4
`define BM_ADC_FLAG 5

// Sticky event status and mask layout
`define STAT_W 4
`define ST_CMP 0
`define ST_MULTI 1
`define ST_PWM 2
`define ST_WAKE 3

// Call vectors
`define VEC_CMP 8'h04
`define VEC_EXT0 8'h08
`define VEC_MULTI 8'h0C
`define VEC_PWM 8'h10
`define VEC_TMR0 8'h14
`define VEC_TMR1 8'h18

// Register select codes
`define SEL_CTRL0 3'h0
`define SEL_CTRL1 3'h1
`define SEL_MCTRL 3'h2
`define SEL_STAT 3'h3
`define SEL_MASK 3'h4
`define SEL_SVC 3'h5
`define SEL_NONE 3'h7

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RST_BYTE 8'h00

`endif

/* rtl/irq_pkg.sv */
// State types of the interrupt controller and its helpers.
// Assumes irq_defines.svh is on the include path.
`include "irq_defines.svh"

package irq_pkg;

   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } edge_state_type;

   typedef struct packed {
      logic aw_full;
      logic [7:0] awaddr;
      logic w_full;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_state_type;

   typedef struct packed {
      logic gie;
      logic cmp_en;
      logic multi_en;
      logic cmp_flag;
      logic pwm_en;
      logic pwm_flag;
      logic multi_flag;
      logic adc_en;
      logic ext1_en;
      logic ext1_flag;
      logic adc_flag;
      logic [`STAT_W-1:0] status;
      logic [`STAT_W-1:0] mask;
      logic [7:0] vector;
      logic call;
      logic pop;
      logic wake;
      logic [2:0] other_ack;
   } irq_state_type;

endpackage

/* rtl/irq_edge_detect.sv */
// Edge detector with optional two-flop synchroniser.
// Assumes din is asynchronous when SYNC is set, same-clock otherwise.
`timescale 1ns/1ps
`default_nettype none

module irq_edge_detect #(
   parameter bit SYNC = 1'b1,
   parameter bit FALLING = 1'b1
) (
   input wire logic ref_clk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic din, // monitored level
   output logic edge_pulse // one-cycle pulse per edge
);

   irq_pkg::edge_state_type q;
   irq_pkg::edge_state_type d;
   logic level;

   // Only s2 reads s1; with SYNC set detection looks at s2 alone, else at din
   assign level = SYNC ? q.s2 : din;

   always_comb begin
      d = q;
      d.s1 = din;
      d.s2 = q.s1;
      d.prev = level;
   end

   // Idle level at reset avoids a false edge on release
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '{s1: FALLING, s2: FALLING, prev: FALLING};
      end else begin
         q <= d;
      end
   end

   assign edge_pulse = FALLING ? (q.prev & ~level) : (~q.prev & level);

endmodule

`default_nettype wire

/* rtl/irq_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read under way at a time.
// Assumes the register file answers decode and read data combinationally.
`timescale 1ns/1ps
`default_nettype none
`include "irq_defines.svh"

module irq_axil_slave (
   input wire logic ref_clk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   output logic wr_en, // register write strobe
   output logic [7:0] wr_addr, // register write address
   output logic [31:0] wr_data, // register write data
   output logic [3:0] wr_strb, // register write strobes
   input wire logic wr_ok, // write address is mapped
   output logic rd_en, // register read strobe
   output logic [7:0] rd_addr, // register read address
   input wire logic [31:0] rd_data, // register read data
   input wire logic rd_ok // read address is mapped
);

   irq_pkg::axi_state_type q;
   irq_pkg::axi_state_type d;

   assign wr_en = q.aw_full & q.w_full & ~q.bvalid;
   assign rd_en = s_axi_arvalid & ~q.rvalid;

   always_comb begin
      d = q;
      if (s_axi_awvalid && !q.aw_full) begin
         d.aw_full = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.w_full) begin
         d.w_full = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (wr_en) begin
         d.aw_full = 1'b0;
         d.w_full = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (rd_en) begin
         d.rvalid = 1'b1;
         d.rdata = rd_ok ? rd_data : 32'h00000000;
         d.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Holding slots keep address and data apart, so either may come first
   assign s_axi_awready = ~q.aw_full;
   assign s_axi_wready = ~q.w_full;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = ~q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign wr_addr = q.awaddr;
   assign wr_data = q.wdata;
   assign wr_strb = q.wstrb;
   assign rd_addr = s_axi_araddr;

endmodule

`default_nettype wire

/* rtl/irq_ctrl.sv */
// Interrupt controller for comparator, PWM and shared multi-function
// sources, with priority service towards the core and power-down wake.
// Assumes the core gives a T2 phase pulse, a stack-full level and a
// return pulse on the same clock; cmp_out and ext1_irq_pin are async.
//
// Contract
// - Comparator taken only with global and own enable
// - Comparator falling edge sets its flag
// - Comparator service calls vector 04H
// - Comparator service clears its flag and global
// - PWM taken only with global and own enable
// - PWM high side going active sets flag
// - PWM service calls vector 10H
// - PWM service clears its flag and global
// - Multi needs global, own and sub enable
// - External-1 edge or A/D done sets multi flag
// - Multi service calls vector 0CH
// - Multi service keeps sub flags, clears multi, global
// - Flags persist until serviced or software-cleared
// - Every source wakes core from power down
// - Only program counter is pushed on entry
// - Fixed priority among simultaneous requests
// - No acknowledge while stack is full
// - Service only on a T2 phase pulse
`timescale 1ns/1ps
`default_nettype none
`include "irq_defines.svh"

module irq_ctrl (
   input wire logic ref_clk, // system clock, 10 MHz
   input wire logic resetn, // async reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic cmp_out, // analog comparator output, async
   input wire logic pwm_high_side_output, // PWM high side, active high
   input wire logic ext1_irq_pin, // external interrupt 1 pin, async
   input wire logic adc_done, // A/D conversion complete pulse
   input wire logic [2:0] other_req, // ext0, timer0, timer1 requests
   input wire logic t2_pulse, // machine phase T2 pulse
   input wire logic stack_full, // hardware stack full
   input wire logic return_from_interrupt_pulse, // return_from_interrupt executed
   input wire logic power_down, // core is in power down
   output logic pc_push, // push program counter and call
   output logic [7:0] call_vector, // vector of the call
   output logic pc_pop, // restore program counter
   output logic [2:0] other_ack, // serviced ext0, timer0, timer1
   output logic wake_up, // wake core from power down
   output logic irq // level interrupt to software
);

   irq_pkg::irq_state_type q;
   irq_pkg::irq_state_type d;

   logic cmp_fall;
   logic pwm_rise;
   logic ext1_fall;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic rd_en;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic [2:0] wsel;
   logic [2:0] rsel;
   logic cmp_pend;
   logic multi_pend;
   logic pwm_pend;
   logic take;
   logic [7:0] ctrl0_v;
   logic [7:0] ctrl1_v;
   logic [7:0] mctrl_v;

   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      case (a)
         `OFF_CTRL0: reg_sel = `SEL_CTRL0;
         `OFF_CTRL1: reg_sel = `SEL_CTRL1;
         `OFF_MCTRL: reg_sel = `SEL_MCTRL;
         `OFF_STAT: reg_sel = `SEL_STAT;
         `OFF_MASK: reg_sel = `SEL_MASK;
         `OFF_SVC: reg_sel = `SEL_SVC;
         default: reg_sel = `SEL_NONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Event inputs

   irq_edge_detect #(.SYNC(1'b1), .FALLING(1'b1)) u_cmp_edge (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .din(cmp_out),
      .edge_pulse(cmp_fall)
   );

   // PWM logic shares the clock, so no synchroniser
   irq_edge_detect #(.SYNC(1'b0), .FALLING(1'b0)) u_pwm_edge (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .din(pwm_high_side_output),
      .edge_pulse(pwm_rise)
   );

   irq_edge_detect #(.SYNC(1'b1), .FALLING(1'b1)) u_ext1_edge (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .din(ext1_irq_pin),
      .edge_pulse(ext1_fall)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register bus

   irq_axil_slave u_bus (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wsel != `SEL_NONE),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rsel != `SEL_NONE)
   );

   assign wsel = reg_sel(wr_addr);
   assign rsel = reg_sel(rd_addr);

   always_comb begin
      ctrl0_v = `RST_BYTE;
      ctrl0_v[`B0_GIE] = q.gie;
      ctrl0_v[`B0_CMP_EN] = q.cmp_en;
      ctrl0_v[`B0_MULTI_EN] = q.multi_en;
      ctrl0_v[`B0_CMP_FLAG] = q.cmp_flag;
      ctrl1_v = `RST_BYTE;
      ctrl1_v[`B1_PWM_EN] = q.pwm_en;
      ctrl1_v[`B1_PWM_FLAG] = q.pwm_flag;
      ctrl1_v[`B1_MULTI_FLAG] = q.multi_flag;
      mctrl_v = `RST_BYTE;
      mctrl_v[`BM_ADC_EN] = q.adc_en;
      mctrl_v[`BM_EXT1_EN] = q.ext1_en;
      mctrl_v[`BM_EXT1_FLAG] = q.ext1_flag;
      mctrl_v[`BM_ADC_FLAG] = q.adc_flag;
   end

   always_comb begin
      case (rsel)
         `SEL_CTRL0: rd_data = {24'h000000, ctrl0_v};
         `SEL_CTRL1: rd_data = {24'h000000, ctrl1_v};
         `SEL_MCTRL: rd_data = {24'h000000, mctrl_v};
         `SEL_STAT: rd_data = {28'h0000000, q.status};
         `SEL_MASK: rd_data = {28'h0000000, q.mask};
         `SEL_SVC: rd_data = {24'h000000, q.vector};
         default: rd_data = 32'h00000000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Request qualification and service

   assign cmp_pend = q.cmp_en & q.cmp_flag;
   assign pwm_pend = q.pwm_en & q.pwm_flag;
   assign multi_pend = q.multi_en & (q.adc_en | q.ext1_en) & q.multi_flag;
   // Pending stays pending while the stack is full or off-phase
   assign take = t2_pulse & q.gie & ~stack_full &
      (cmp_pend | multi_pend | pwm_pend | (|other_req));

   always_comb begin
      d = q;
      d.call = 1'b0;
      d.pop = 1'b0;
      d.other_ack = 3'h0;
      // Software writes first, so hardware sets below win over clears
      if (wr_en && wr_strb[0]) begin
         case (wsel)
            `SEL_CTRL0: begin
               d.gie = wr_data[`B0_GIE];
               d.cmp_en = wr_data[`B0_CMP_EN];
               d.multi_en = wr_data[`B0_MULTI_EN];
               d.cmp_flag = wr_data[`B0_CMP_FLAG];
            end
            `SEL_CTRL1: begin
               d.pwm_en = wr_data[`B1_PWM_EN];
               d.pwm_flag = wr_data[`B1_PWM_FLAG];
               d.multi_flag = wr_data[`B1_MULTI_FLAG];
            end
            `SEL_MCTRL: begin
               d.adc_en = wr_data[`BM_ADC_EN];
               d.ext1_en = wr_data[`BM_EXT1_EN];
               d.ext1_flag = wr_data[`BM_EXT1_FLAG];
               d.adc_flag = wr_data[`BM_ADC_FLAG];
            end
            `SEL_MASK: d.mask = wr_data[`STAT_W-1:0];
            default: d.mask = q.mask;
         endcase
      end
      if (rd_en && rsel == `SEL_STAT) begin
         d.status = '0;
      end
      if (return_from_interrupt_pulse) begin
         d.gie = 1'b1;
         d.pop = 1'b1;
      end
      if (take) begin
         d.call = 1'b1;
         d.gie = 1'b0;
         if (cmp_pend) begin
            d.vector = `VEC_CMP;
            d.cmp_flag = 1'b0;
            d.status[`ST_CMP] = 1'b1;
         end else if (other_req[0]) begin
            d.vector = `VEC_EXT0;
            d.other_ack[0] = 1'b1;
         end else if (multi_pend) begin
            d.vector = `VEC_MULTI;
            d.multi_flag = 1'b0;
            d.status[`ST_MULTI] = 1'b1;
         end else if (pwm_pend) begin
            d.vector = `VEC_PWM;
            d.pwm_flag = 1'b0;
            d.status[`ST_PWM] = 1'b1;
         end else if (other_req[1]) begin
            d.vector = `VEC_TMR0;
            d.other_ack[1] = 1'b1;
         end else begin
            d.vector = `VEC_TMR1;
            d.other_ack[2] = 1'b1;
         end
      end
      // Hardware sets last: an event in a clearing cycle is kept
      if (cmp_fall) begin
         d.cmp_flag = 1'b1;
      end
      if (pwm_rise) begin
         d.pwm_flag = 1'b1;
      end
      if (ext1_fall) begin
         d.ext1_flag = 1'b1;
      end
      if (adc_done) begin
         d.adc_flag = 1'b1;
      end
      if (ext1_fall || adc_done) begin
         d.multi_flag = 1'b1;
      end
      // Wake ignores global enable so a masked core still resumes
      d.wake = power_down &
         (cmp_pend | multi_pend | pwm_pend | (|other_req));
      if (d.wake && !q.wake) begin
         d.status[`ST_WAKE] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pc_push = q.call;
   assign call_vector = q.vector;
   assign pc_pop = q.pop;
   assign other_ack = q.other_ack;
   assign wake_up = q.wake;
   assign irq = |(q.status & q.mask);

   ////////////////////////////////////////////////////////////////////////
   // Checks

   chk_cmp_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
      (pc_push && call_vector == `VEC_CMP) |->
      $past(q.gie && q.cmp_en && q.cmp_flag))
      else $error("comparator call without its enables");

   chk_cmp_flag_set: assert property (@(posedge ref_clk) disable iff (!resetn)
      cmp_fall |=> q.cmp_flag)
      else $error("comparator edge did not set its flag");

   chk_cmp_vector: assert property (@(posedge ref_clk) disable iff (!resetn)
      (t2_pulse && q.gie && !stack_full && cmp_pend) |=>
      (pc_push && call_vector == `VEC_CMP))
      else $error("comparator service missed vector");

   chk_svc_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      (pc_push && call_vector == `VEC_CMP) |->
      (!q.gie || $past(return_from_interrupt_pulse)) &&
      (!q.cmp_flag || $past(cmp_fall)))
      else $error("comparator service left flag or enable");

   chk_pwm_flag_set: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(pwm_high_side_output) |=> q.pwm_flag)
      else $error("PWM active edge did not set its flag");

   chk_pwm_vector: assert property (@(posedge ref_clk) disable iff (!resetn)
      (pc_push && call_vector == `VEC_PWM) |->
      $past(q.pwm_en && q.pwm_flag && !cmp_pend && !multi_pend))
      else $error("PWM call out of order or unqualified");

   chk_multi_keep: assert property (@(posedge ref_clk) disable iff (!resetn)
      (take && multi_pend && !cmp_pend && !other_req[0] && q.ext1_flag &&
      !(wr_en && wsel == `SEL_MCTRL)) |=>
      (q.ext1_flag && call_vector == `VEC_MULTI))
      else $error("multi service lost a source flag");

   chk_stack_full: assert property (@(posedge ref_clk) disable iff (!resetn)
      stack_full |=> !pc_push)
      else $error("call taken with stack full");

   chk_t2_phase: assert property (@(posedge ref_clk) disable iff (!resetn)
      pc_push |-> $past(t2_pulse))
      else $error("call outside T2 phase");

   chk_return_from_interrupt_gie: assert property (@(posedge ref_clk) disable iff (!resetn)
      (return_from_interrupt_pulse && !t2_pulse) |=> (q.gie && pc_pop))
      else $error("return did not restore global enable");

   chk_wake: assert property (@(posedge ref_clk) disable iff (!resetn)
      (power_down && pwm_pend) |=> wake_up)
      else $error("pending request did not wake core");

endmodule

`default_nettype wire

/* tb/core_model.sv */
// Core-side model: T2 phase pulses, an eight-deep stack, return pulses.
// Assumes the controller pushes and pops on one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module core_model (
   input wire logic ref_clk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic pc_push, // call taken
   input wire logic pc_pop, // counter restored
   input wire logic ret_req, // bench asks for a return
   input wire logic fill, // bench holds the stack full
   output logic t2_pulse, // T2 phase, one cycle in four
   output logic stack_full, // stack full level
   output logic return_from_interrupt_pulse // return executed
);
   logic [1:0] phase_q;
   logic [3:0] depth_q;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         phase_q <= 2'h0;
         depth_q <= 4'h0;
         return_from_interrupt_pulse <= 1'b0;
      end else begin
         phase_q <= phase_q + 2'h1;
         return_from_interrupt_pulse <= ret_req;
         depth_q <= depth_q + {3'h0, pc_push} - {3'h0, pc_pop};
      end
   end

   assign t2_pulse = (phase_q == 2'h3);
   // Fill avoids eight nested calls just to reach a full stack
   assign stack_full = fill || (depth_q == 4'h8);
endmodule

`default_nettype wire

/* tb/irq_ctrl_test.sv */
// Self-checking bench for irq_ctrl with the core model on its far side.
// Assumes irq_defines.svh on the include path and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "irq_defines.svh"

module irq_ctrl_test;
   logic ref_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmp_out, adc_done;
   logic pwm_high_side_output, ext1_irq_pin, t2_pulse, stack_full, t2_q;
   logic return_from_interrupt_pulse, power_down, pc_push, pc_pop, wake_up, irq;
   logic ret_req, fill;
   logic [7:0] s_axi_awaddr, s_axi_araddr, call_vector;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, src;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [2:0] other_req, other_ack;
   logic [7:0] pushq[$];
   int bad_count, comparisons, cycles, pops, rets, seed, k;

   irq_ctrl dut (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_out,
      .pwm_high_side_output, .ext1_irq_pin, .adc_done, .other_req,
      .t2_pulse, .stack_full, .return_from_interrupt_pulse, .power_down, .pc_push,
      .call_vector, .pc_pop, .other_ack, .wake_up, .irq);
   core_model core (.ref_clk, .resetn, .pc_push, .pc_pop, .ret_req,
      .fill, .t2_pulse, .stack_full, .return_from_interrupt_pulse);

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      cycles++;
      if (pc_push === 1'b1) begin
         pushq.push_back(call_vector);
         chk(t2_q, 1'b1);
      end
      t2_q <= t2_pulse;
      if (pc_pop === 1'b1)
         pops++;
      // Owners drop their level once serviced
      if (other_ack != 3'h0)
         other_req <= other_req & ~other_ack;
      if (cycles == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
            break;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready)
            break;
      end
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk(rd, e);
   endtask

   task automatic ret();
      @(posedge ref_clk);
      ret_req <= 1'b1;
      @(posedge ref_clk);
      ret_req <= 1'b0;
      rets++;
   endtask

   task automatic expect_push(input logic [7:0] v);
      int n;
      n = 0;
      while (pushq.size() == 0 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      chk(pushq.size(), 1);
      if (pushq.size() != 0)
         chk(pushq.pop_front(), v);
   endtask

   function automatic logic [7:0] prio_vec(input int i);
      case (i)
         0: return `VEC_CMP;
         1: return `VEC_EXT0;
         2: return `VEC_MULTI;
         3: return `VEC_PWM;
         4: return `VEC_TMR0;
         default: return `VEC_TMR1;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 33;
      resetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, ret_req, fill, t2_q} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      {cmp_out, ext1_irq_pin, pwm_high_side_output, adc_done} = 4'hC;
      {other_req, power_down} = 4'h0;
      tick(12);
      resetn <= 1'b1;
      for (k = 0; k < 6; k++)
         rdchk(8'(4 * k), 32'h0);
      rdchk(8'h1C, 32'h0);
      chk(rsp, `RESP_SLVERR);
      wr(8'h1C, 32'hFF);
      chk(rsp, `RESP_SLVERR);
      // Comparator edge with the global enable off
      wr(`OFF_CTRL0, 32'h02);
      cmp_out <= 1'b0;
      tick(2 + ($random(seed) & 3));
      cmp_out <= 1'b1;
      tick(12);
      chk(pushq.size(), 0);
      rdchk(`OFF_CTRL0, 32'h12);
      wr(`OFF_CTRL0, 32'h13);
      expect_push(`VEC_CMP);
      rdchk(`OFF_CTRL0, 32'h02);
      ret();
      // PWM request held back by a full stack
      fill <= 1'b1;
      wr(`OFF_CTRL1, 32'h01);
      wr(`OFF_CTRL0, 32'h01);
      pwm_high_side_output <= 1'b1;
      tick(1 + ($random(seed) & 3));
      pwm_high_side_output <= 1'b0;
      tick(12);
      chk(pushq.size(), 0);
      rdchk(`OFF_CTRL1, 32'h11);
      fill <= 1'b0;
      expect_push(`VEC_PWM);
      rdchk(`OFF_CTRL1, 32'h01);
      rdchk(`OFF_CTRL0, 32'h00);
      ret();
      // Every pair of sub-enables, either source at random
      for (k = 0; k < 4; k++) begin
         wr(`OFF_CTRL1, 32'h0);
         wr(`OFF_CTRL0, 32'h04);
         wr(`OFF_MCTRL, 32'(k));
         src = ($random(seed) & 1) ? 32'h10 : 32'h20;
         ext1_irq_pin <= (src != 32'h10);
         adc_done <= (src == 32'h20);
         tick(1);
         adc_done <= 1'b0;
         tick(3);
         ext1_irq_pin <= 1'b1;
         tick(8);
         wr(`OFF_CTRL0, 32'h05);
         tick(12);
         if (k != 0)
            expect_push(`VEC_MULTI);
         chk(pushq.size(), 0);
         rdchk(`OFF_MCTRL, 32'(k) | src);
         rdchk(`OFF_CTRL1, (k != 0) ? 32'h0 : 32'h20);
         if (k != 0)
            ret();
         wr(`OFF_CTRL0, 32'h0);
         wr(`OFF_MCTRL, 32'h0);
      end
      // Six requests at once, served one per return
      wr(`OFF_CTRL0, 32'h06);
      wr(`OFF_CTRL1, 32'h01);
      wr(`OFF_MCTRL, 32'h01);
      cmp_out <= 1'b0;
      pwm_high_side_output <= 1'b1;
      adc_done <= 1'b1;
      other_req <= 3'h7;
      tick(1);
      adc_done <= 1'b0;
      pwm_high_side_output <= 1'b0;
      tick(4);
      cmp_out <= 1'b1;
      tick(6);
      wr(`OFF_CTRL0, 32'h17);
      for (k = 0; k < 6; k++) begin
         expect_push(prio_vec(k));
         ret();
      end
      tick(3);
      chk(pops, rets);
      // Status, mask, level output and wake from power down
      chk(irq, 1'b0);
      rdchk(`OFF_STAT, 32'h07);
      rdchk(`OFF_STAT, 32'h00);
      wr(`OFF_MASK, 32'h08 | ($random(seed) & 7));
      wr(`OFF_CTRL0, 32'h02);
      power_down <= 1'b1;
      cmp_out <= 1'b0;
      tick(3);
      cmp_out <= 1'b1;
      tick(4);
      chk(wake_up, 1'b1);
      tick(2);
      chk(irq, 1'b1);
      rdchk(`OFF_STAT, 32'h08);
      tick(2);
      chk(irq, 1'b0);
      power_down <= 1'b0;
      tally_and_finish();
   end
endmodule

`default_nettype wire
